/* File: design/batch_defines.svh */
// Constants shared by the batch run controller files.
// Assumes inclusion by bare name from the package, the output gate, the top module and the bench.
//
// What this block does
// - Pause suspends the batch, batch outputs off, concurrent and timer outputs kept.
// - Start while paused resumes at the same step, outputs come back.
// - Reset stops the batch and returns the step to the first.
// - Stop halts the batch and drives all its outputs inactive.
// - With run permit unassigned, permit counts as closed; e-stop ignored.
// - Permit decode: both closed start, stop open abort, both open pause.
// - Pause input pauses, keeps concurrent outputs, holds while the input stays low.
// - Pause input returning high lets the paused batch continue.
// - Stop input pauses the batch with every output off, concurrent included.
// - Release stop then start resumes from the interrupted step.
// - Stop, abort, release, start restarts at first step; no start stays aborted.
// - Concurrent output drives while its referenced step is active.
// - Continuous outputs go low when met; batch outputs active until met.
`ifndef BATCH_DEFINES_SVH
`define BATCH_DEFINES_SVH

// ---------------------------------------------------------------
// Sizes
// ---------------------------------------------------------------
`define NUM_OUT 8
`define STEP_W 3

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define OFF_CTRL 8'h00
`define OFF_CFG 8'h04
`define OFF_CONC 8'h08
`define OFF_STATUS 8'h0c

`define CTRL_START 0
`define CTRL_PAUSE 1
`define CTRL_RESET 2
`define CTRL_STOP 3

`define CFG_PERMIT_BIT 0
`define CFG_LAST_LSB 8
`define CFG_CONT_LSB 16
`define CFG_RST 32'h0000_0701
`define CONC_RST 32'h0000_0000

`endif

/* File: design/batch_pkg.sv */
// Types shared by the batch run controller files.
// Assumes the defines header is on the include path.
`include "batch_defines.svh"

package batch_pkg;

    // ---------------------------------------------------------------
    // Control state
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RUNNING,
        ST_PAUSED,
        ST_STOPPED,
        ST_ABORTED
    } state_e;

    typedef logic [`STEP_W-1:0] step_t;
    typedef logic [`NUM_OUT-1:0] outs_t;

    function automatic outs_t step_onehot(input step_t s);
        step_onehot = outs_t'(1) << s;
    endfunction

endpackage

/* File: design/input_sync.sv */
// Two-stage synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to CLK_SYS; first stage read by second only.
`timescale 1ns/10ps

module input_sync #(
    parameter int W = 6,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule

/* File: design/output_gate.sv */
// Per-output activity from control state, step and setpoint settings.
// Assumes same-clock inputs; result is registered by the caller.
`timescale 1ns/10ps
`include "batch_defines.svh"

module output_gate (
    input batch_pkg::state_e state,
    input batch_pkg::step_t step,
    input wire logic [31:0] conc_cfg,
    input batch_pkg::outs_t cont_mask,
    input batch_pkg::outs_t cont_met,
    input batch_pkg::outs_t timer_act,
    output batch_pkg::outs_t batch_act,
    output batch_pkg::outs_t keep_act,
    output batch_pkg::outs_t conc_act,
    output batch_pkg::outs_t cont_act
);
    import batch_pkg::*;

    logic live;
    outs_t hot;

    assign live = (state == ST_RUNNING) || (state == ST_PAUSED);
    assign hot = step_onehot(step);

    genvar j;
    generate
        for (j = 0; j < `NUM_OUT; j++) begin : g_bit
            // batch output held until step met
            assign batch_act[j] = (state == ST_RUNNING) && hot[j];
            assign conc_act[j] = live && conc_cfg[4*j+3] && (conc_cfg[4*j+:3] == step);
            assign keep_act[j] = conc_act[j] || (live && timer_act[j]);
            assign cont_act[j] = cont_mask[j] && cont_met[j] && (state != ST_STOPPED);
        end
    endgenerate

endmodule

/* File: design/batch_run_controller.sv */
// Batch sequencing controller with AHB-Lite register access.
// Assumes one slave on the bus, pins asynchronous, step and timer inputs same clock.
//
// The register offsets and the AHB-Lite register port were left to the implementer.
`timescale 1ns/10ps
`include "batch_defines.svh"

module batch_run_controller (
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic [31:0] HRDATA,
    output logic HRESP,
    input wire logic PERMIT_STOP,
    input wire logic PERMIT_SEL,
    input wire logic DIN_START_N,
    input wire logic DIN_RESET_N,
    input wire logic DIN_PAUSE_N,
    input wire logic DIN_STOP_N,
    input wire logic STEP_MET,
    input batch_pkg::outs_t CONT_MET,
    input batch_pkg::outs_t TIMER_ACT,
    output batch_pkg::outs_t SP_OUT_N
);
    import batch_pkg::*;

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    logic accept;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] hrdata_q;
    logic [31:0] rd_d;
    logic cfg_permit_q;
    step_t cfg_last_q;
    outs_t cfg_cont_q;
    logic [31:0] conc_q;
    logic [3:0] sw_req;
    logic [5:0] pins_s;
    logic [5:0] pins_prev_q;
    logic stop_s, sel_s;
    logic eff_stop;
    logic permit_go, go_q, go_ev;
    logic abort_req, permit_pause;
    logic din_start_ev, din_reset_ev, din_stop_ev, din_pause_lvl, pause_rel;
    logic stop_req, reset_req, pause_req, start_req, start_ok;
    state_e state_q, state_d;
    step_t step_q, step_d;
    outs_t batch_act, keep_act, conc_act, cont_act, act;
    outs_t out_n_q;

    function automatic logic fell(input logic cur, input logic prev);
        fell = !cur && prev;
    endfunction

    // ---------------------------------------------------------------
    // AHB-Lite slave
    // ---------------------------------------------------------------
    // Zero wait states keep the master simple; every answer is OKAY
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = hrdata_q;
    assign accept = HSEL && HTRANS[1] && HREADY;

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else if (HREADY) begin
            wr_pend_q <= accept && HWRITE;
            wr_addr_q <= HADDR[7:0];
        end
    end

    always_comb begin
        case (HADDR[7:0])
            `OFF_CFG: rd_d = {8'h00, cfg_cont_q, 5'h00, cfg_last_q, 7'h00, cfg_permit_q};
            `OFF_CONC: rd_d = conc_q;
            `OFF_STATUS: rd_d = {14'h0000, sel_s, stop_s, ~out_n_q, 1'b0, step_q, 1'b0, 3'(state_q)};
            default: rd_d = 32'h0000_0000;
        endcase
    end

    // Read data captured in the address phase, stands in the data phase
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            hrdata_q <= 32'h0000_0000;
        end else if (accept && !HWRITE) begin
            hrdata_q <= rd_d;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            cfg_permit_q <= 1'(`CFG_RST >> `CFG_PERMIT_BIT);
            cfg_last_q <= step_t'(`CFG_RST >> `CFG_LAST_LSB);
            cfg_cont_q <= outs_t'(`CFG_RST >> `CFG_CONT_LSB);
            conc_q <= `CONC_RST;
        end else if (wr_pend_q) begin
            if (wr_addr_q == `OFF_CFG) begin
                cfg_permit_q <= HWDATA[`CFG_PERMIT_BIT];
                cfg_last_q <= HWDATA[`CFG_LAST_LSB+:`STEP_W];
                cfg_cont_q <= HWDATA[`CFG_CONT_LSB+:`NUM_OUT];
            end
            if (wr_addr_q == `OFF_CONC) begin
                conc_q <= HWDATA;
            end
        end
    end

    // Control word bits act as one-cycle request pulses
    assign sw_req = (wr_pend_q && wr_addr_q == `OFF_CTRL) ? HWDATA[3:0] : 4'h0;

    // ---------------------------------------------------------------
    // Pin inputs
    // ---------------------------------------------------------------
    // separate inputs for stop and selector
    input_sync #(.W(6), .RST_VAL(6'h3f)) u_sync (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .d({PERMIT_STOP, PERMIT_SEL, DIN_START_N, DIN_RESET_N, DIN_PAUSE_N, DIN_STOP_N}),
        .q(pins_s)
    );

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            pins_prev_q <= 6'h3f;
            go_q <= 1'b1;
        end else begin
            pins_prev_q <= pins_s;
            go_q <= permit_go;
        end
    end

    assign stop_s = pins_s[5];
    assign sel_s = pins_s[4];
    assign din_start_ev = fell(pins_s[3], pins_prev_q[3]);
    assign din_reset_ev = fell(pins_s[2], pins_prev_q[2]);
    assign din_pause_lvl = !pins_s[1];
    assign pause_rel = pins_s[1] && !pins_prev_q[1];
    assign din_stop_ev = fell(pins_s[0], pins_prev_q[0]);

    assign eff_stop = cfg_permit_q ? stop_s : 1'b1;
    assign permit_go = eff_stop && sel_s;
    assign go_ev = permit_go && !go_q;
    assign abort_req = !eff_stop && sel_s;
    assign permit_pause = !eff_stop && !sel_s;

    assign stop_req = sw_req[`CTRL_STOP] || din_stop_ev;
    assign reset_req = sw_req[`CTRL_RESET] || din_reset_ev;
    // pause input held low keeps pausing
    assign pause_req = sw_req[`CTRL_PAUSE] || din_pause_lvl || permit_pause;
    assign start_req = sw_req[`CTRL_START] || din_start_ev || go_ev || pause_rel;
    assign start_ok = start_req && eff_stop;

    // ---------------------------------------------------------------
    // Batch state machine
    // ---------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        step_d = step_q;
        // stop first, then abort, reset, pause, start
        if (stop_req && (state_q == ST_RUNNING || state_q == ST_PAUSED)) begin
            // stop keeps step, all outputs off
            state_d = ST_STOPPED;
        end else if (abort_req) begin
            state_d = ST_ABORTED;
            step_d = '0;
        end else if (reset_req) begin
            state_d = ST_IDLE;
            step_d = '0;
        end else if (pause_req) begin
            if (state_q == ST_RUNNING) begin
                state_d = ST_PAUSED;
            end
        end else if (start_ok) begin
            case (state_q)
                ST_IDLE, ST_ABORTED: begin
                    state_d = ST_RUNNING;
                    step_d = '0;
                end
                ST_PAUSED, ST_STOPPED: begin
                    state_d = ST_RUNNING;
                end
                default: begin
                    state_d = state_q;
                end
            endcase
        end else if (state_q == ST_RUNNING && STEP_MET) begin
            if (step_q == cfg_last_q) begin
                state_d = ST_IDLE;
                step_d = '0;
            end else begin
                step_d = step_q + step_t'(1);
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            state_q <= ST_IDLE;
            step_q <= '0;
        end else begin
            state_q <= state_d;
            step_q <= step_d;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    output_gate u_gate (
        .state(state_q),
        .step(step_q),
        .conc_cfg(conc_q),
        .cont_mask(cfg_cont_q),
        .cont_met(CONT_MET),
        .timer_act(TIMER_ACT),
        .batch_act(batch_act),
        .keep_act(keep_act),
        .conc_act(conc_act),
        .cont_act(cont_act)
    );

    assign act = batch_act | keep_act | cont_act;

    // Pins are active low; registered so they never glitch
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            out_n_q <= '1;
        end else begin
            out_n_q <= ~act;
        end
    end

    assign SP_OUT_N = out_n_q;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (SYS_RST);

    a_pause_suspend: assert property (
        (state_q == ST_RUNNING && pause_req && !stop_req && !abort_req && !reset_req)
        |=> (state_q == ST_PAUSED && $stable(step_q)))
        else $error("pause did not suspend the batch");

    a_pause_outs_off: assert property (
        (state_q == ST_PAUSED)
        |=> ((out_n_q | $past(keep_act) | $past(cont_act)) == 8'hff))
        else $error("batch output active while paused");

    a_resume_step: assert property (
        (state_q == ST_PAUSED && start_ok && !pause_req && !stop_req && !abort_req && !reset_req)
        |=> (state_q == ST_RUNNING && $stable(step_q)))
        else $error("resume did not keep the step");

    a_reset_first: assert property (
        (reset_req && !stop_req && !abort_req)
        |=> (state_q == ST_IDLE && step_q == 3'h0))
        else $error("reset did not return to first step");

    a_stop_all_off: assert property (
        (stop_req && (state_q == ST_RUNNING || state_q == ST_PAUSED))
        |=> (state_q == ST_STOPPED) ##1 (out_n_q == 8'hff))
        else $error("stop left an output active");

    a_permit_absent: assert property (
        !cfg_permit_q |-> (eff_stop && !abort_req && !permit_pause))
        else $error("e-stop acted with permit unassigned");

    a_abort_decode: assert property (
        (abort_req && !stop_req)
        |=> (state_q == ST_ABORTED && step_q == 3'h0))
        else $error("abort decode missed");

    a_conc_kept: assert property (
        (state_q == ST_PAUSED && conc_act != 8'h00)
        |=> ((~out_n_q & $past(conc_act)) == $past(conc_act)))
        else $error("concurrent output dropped in pause");

    a_pause_release: assert property (
        (state_q == ST_PAUSED && pause_rel && !pause_req && !stop_req && !abort_req && !reset_req
            && eff_stop)
        |=> (state_q == ST_RUNNING))
        else $error("pause release did not resume");

    a_start_blocked: assert property (
        (cfg_permit_q && !stop_s) |-> !start_ok)
        else $error("start taken with stop latched");

    a_stop_resume: assert property (
        (state_q == ST_STOPPED && start_ok && !pause_req && !stop_req && !abort_req && !reset_req)
        |=> (state_q == ST_RUNNING && $stable(step_q)))
        else $error("stop resume changed the step");

    a_abort_restart: assert property (
        (state_q == ST_ABORTED && start_ok && !pause_req && !abort_req && !reset_req)
        |=> (state_q == ST_RUNNING && step_q == 3'h0))
        else $error("restart after abort not at first step");

    a_cont_low: assert property (
        ((cfg_cont_q & CONT_MET) != 8'h00 && state_q != ST_STOPPED)
        |=> ((out_n_q & $past(cfg_cont_q & CONT_MET)) == 8'h00))
        else $error("met continuous output not low");

    c_pause_resume: cover property (
        (state_q == ST_PAUSED) ##1 (state_q == ST_RUNNING));
    c_stop_resume: cover property (
        (state_q == ST_STOPPED) ##1 (state_q == ST_RUNNING));
    c_abort: cover property (
        (state_q == ST_RUNNING) ##1 (state_q == ST_ABORTED));
    c_batch_done: cover property (
        (state_q == ST_RUNNING && STEP_MET && step_q == cfg_last_q) ##1 (state_q == ST_IDLE));

endmodule

/* File: tb/operator_panel.sv */
// Model of the operator side: e-stop, start/abort selector, digital inputs.
// Assumes its tasks are called from the bench; pins change after CLK_SYS edges.
`timescale 1ns/10ps

module operator_panel (
    input wire logic clk,
    output logic stop_closed,
    output logic sel_closed,
    output logic start_n,
    output logic reset_n,
    output logic pause_n,
    output logic halt_n
);
    // ---------------------------------------------------------------
    // Pin levels
    // ---------------------------------------------------------------
    // one pin per switch
    initial begin
        stop_closed = 1'b1;
        sel_closed = 1'b0;
        start_n = 1'b1;
        reset_n = 1'b1;
        pause_n = 1'b1;
        halt_n = 1'b1;
    end

    // Long enough for the synchroniser and the output register
    task automatic settle();
        repeat (6) @(posedge clk);
    endtask

    // one step of a switch sequence
    task automatic set_sw(input logic stop, input logic sel);
        @(posedge clk);
        stop_closed <= stop;
        sel_closed <= sel;
        settle();
    endtask

    task automatic set_pause(input logic lvl);
        @(posedge clk);
        pause_n <= lvl;
        settle();
    endtask

    // Momentary key, held low a few cycles as a real contact would be
    task automatic press(input int which);
        @(posedge clk);
        case (which)
            0: start_n <= 1'b0;
            1: reset_n <= 1'b0;
            default: halt_n <= 1'b0;
        endcase
        repeat (4) @(posedge clk);
        start_n <= 1'b1;
        reset_n <= 1'b1;
        halt_n <= 1'b1;
        settle();
    endtask
endmodule

/* File: tb/batch_run_controller_test.sv */
// Self-checking bench for the batch run controller.
// Assumes one AHB-Lite slave with zero wait states and the operator panel model.
`timescale 1ns/10ps
`include "batch_defines.svh"

module batch_run_controller_test;
    import batch_pkg::*;
    logic CLK_SYS, SYS_RST, HSEL, HWRITE, STEP_MET, HREADYOUT, HRESP;
    logic [31:0] HADDR, HWDATA, HRDATA, rd;
    logic [1:0] HTRANS;
    logic [2:0] HSIZE;
    outs_t CONT_MET, TIMER_ACT, SP_OUT_N;
    wire logic PERMIT_STOP, PERMIT_SEL, DIN_START_N, DIN_RESET_N, DIN_PAUSE_N, DIN_STOP_N;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;

    batch_run_controller u_batch_run_controller (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP),
        .PERMIT_STOP(PERMIT_STOP), .PERMIT_SEL(PERMIT_SEL), .DIN_START_N(DIN_START_N),
        .DIN_RESET_N(DIN_RESET_N), .DIN_PAUSE_N(DIN_PAUSE_N), .DIN_STOP_N(DIN_STOP_N),
        .STEP_MET(STEP_MET), .CONT_MET(CONT_MET), .TIMER_ACT(TIMER_ACT), .SP_OUT_N(SP_OUT_N));

    operator_panel u_operator_panel (.clk(CLK_SYS), .stop_closed(PERMIT_STOP), .sel_closed(PERMIT_SEL),
        .start_n(DIN_START_N), .reset_n(DIN_RESET_N), .pause_n(DIN_PAUSE_N), .halt_n(DIN_STOP_N));

    // ---------------------------------------------------------------
    // Clock and hang guard
    // ---------------------------------------------------------------
    initial begin
        CLK_SYS = 1'b0;
        forever #2 CLK_SYS = ~CLK_SYS;
    end

    // Whole run needs well under a tenth of this
    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Single word transfer; read data lands in rd
    task automatic ahb(input logic [7:0] a, input logic wr, input logic [31:0] d);
        @(posedge CLK_SYS);
        HSEL <= 1'b1;
        HADDR <= {24'h0, a};
        HTRANS <= 2'h2;
        HWRITE <= wr;
        do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
        chk({30'h0, HREADYOUT, HRESP}, 32'h2);
    endtask

    // Step is left out of the compare where np is set
    task automatic expect_st(input logic [2:0] s, input logic [2:0] p, input outs_t a, input bit np = 0);
        repeat (3) @(posedge CLK_SYS);
        // Pins looked at mid-cycle, away from the edge that updates them
        @(negedge CLK_SYS);
        chk({24'h0, SP_OUT_N}, {24'h0, ~a});
        ahb(`OFF_STATUS, 1'b0, 32'h0);
        chk({16'h0, rd[17:8], rd[6:4] & {3{!np}}, rd[2:0]}, {16'h0, PERMIT_SEL, PERMIT_STOP, a, p & {3{!np}}, s});
    endtask

    task automatic step_met();
        @(posedge CLK_SYS);
        STEP_MET <= 1'b1;
        @(posedge CLK_SYS);
        STEP_MET <= 1'b0;
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset_vals();
        expect_st(ST_IDLE, 3'h0, 8'h00);
        ahb(`OFF_CFG, 1'b0, 32'h0);
        chk(rd, `CFG_RST);
        ahb(`OFF_CONC, 1'b0, 32'h0);
        chk(rd, `CONC_RST);
        ahb(`OFF_CTRL, 1'b0, 32'h0);
        chk(rd, 32'h0);
        ahb(8'h10, 1'b1, 32'hffff_ffff);
        ahb(8'h10, 1'b0, 32'h0);
        chk(rd, 32'h0);
    endtask

    task automatic t_pause_resume();
        ahb(`OFF_CONC, 1'b1, 32'h0090_0000);
        TIMER_ACT <= 8'h80;
        ahb(`OFF_CTRL, 1'b1, 32'h1);
        expect_st(ST_RUNNING, 3'h0, 8'h81);
        step_met();
        expect_st(ST_RUNNING, 3'h1, 8'ha2);
        ahb(`OFF_CTRL, 1'b1, 32'h2);
        expect_st(ST_PAUSED, 3'h1, 8'ha0);
        ahb(`OFF_CTRL, 1'b1, 32'h1);
        expect_st(ST_RUNNING, 3'h1, 8'ha2);
        ahb(`OFF_CTRL, 1'b1, 32'h3);
        expect_st(ST_PAUSED, 3'h1, 8'ha0);
        ahb(`OFF_CTRL, 1'b1, 32'h1);
        expect_st(ST_RUNNING, 3'h1, 8'ha2);
    endtask

    task automatic t_stop_reset();
        ahb(`OFF_CFG, 1'b1, 32'h0040_0701);
        CONT_MET <= 8'h40;
        expect_st(ST_RUNNING, 3'h1, 8'he2);
        ahb(`OFF_CTRL, 1'b1, 32'hb);
        expect_st(ST_STOPPED, 3'h1, 8'h00);
        ahb(`OFF_CTRL, 1'b1, 32'h1);
        expect_st(ST_RUNNING, 3'h1, 8'he2);
        ahb(`OFF_CTRL, 1'b1, 32'h4);
        expect_st(ST_IDLE, 3'h0, 8'h40);
        CONT_MET <= 8'h00;
        ahb(`OFF_CFG, 1'b1, 32'h0000_0701);
    endtask

    task automatic t_din();
        ahb(`OFF_CTRL, 1'b1, 32'h1);
        u_operator_panel.set_pause(1'b0);
        expect_st(ST_PAUSED, 3'h0, 8'h80);
        u_operator_panel.set_pause(1'b1);
        expect_st(ST_RUNNING, 3'h0, 8'h81);
        u_operator_panel.press(2);
        expect_st(ST_STOPPED, 3'h0, 8'h00);
        u_operator_panel.press(0);
        expect_st(ST_RUNNING, 3'h0, 8'h81);
        step_met();
        u_operator_panel.press(1);
        expect_st(ST_IDLE, 3'h0, 8'h00);
        ahb(`OFF_CFG, 1'b1, 32'h0000_0101);
        ahb(`OFF_CTRL, 1'b1, 32'h4);
        ahb(`OFF_CTRL, 1'b1, 32'h1);
        step_met();
        expect_st(ST_RUNNING, 3'h1, 8'ha2);
        step_met();
        expect_st(ST_IDLE, 3'h0, 8'h00);
        ahb(`OFF_CFG, 1'b1, 32'h0000_0701);
    endtask

    task automatic t_permit();
        u_operator_panel.set_sw(1'b1, 1'b1);
        expect_st(ST_RUNNING, 3'h0, 8'h81);
        u_operator_panel.set_sw(1'b1, 1'b0);
        step_met();
        expect_st(ST_RUNNING, 3'h1, 8'ha2);
        u_operator_panel.set_sw(1'b0, 1'b0);
        ahb(`OFF_CTRL, 1'b1, 32'h1);
        expect_st(ST_PAUSED, 3'h1, 8'ha0);
        u_operator_panel.set_sw(1'b1, 1'b0);
        u_operator_panel.set_sw(1'b1, 1'b1);
        expect_st(ST_RUNNING, 3'h1, 8'ha2);
        u_operator_panel.set_sw(1'b1, 1'b0);
        u_operator_panel.set_sw(1'b0, 1'b0);
        u_operator_panel.set_sw(1'b0, 1'b1);
        expect_st(ST_ABORTED, 3'h0, 8'h00, 1'b1);
        u_operator_panel.set_sw(1'b0, 1'b0);
        u_operator_panel.set_sw(1'b1, 1'b0);
        expect_st(ST_ABORTED, 3'h0, 8'h00, 1'b1);
        u_operator_panel.set_sw(1'b1, 1'b1);
        expect_st(ST_RUNNING, 3'h0, 8'h81);
        u_operator_panel.set_sw(1'b1, 1'b0);
        u_operator_panel.set_sw(1'b0, 1'b0);
        ahb(`OFF_CFG, 1'b1, 32'h0000_0700);
        ahb(`OFF_CTRL, 1'b1, 32'h4);
        ahb(`OFF_CTRL, 1'b1, 32'h1);
        expect_st(ST_RUNNING, 3'h0, 8'h81);
        u_operator_panel.set_sw(1'b0, 1'b1);
        expect_st(ST_RUNNING, 3'h0, 8'h81);
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        SYS_RST = 1'b1;
        HSEL = 1'b0;
        HADDR = 32'h0;
        HTRANS = 2'h0;
        HWRITE = 1'b0;
        HSIZE = 3'h2;
        HWDATA = 32'h0;
        STEP_MET = 1'b0;
        CONT_MET = 8'h00;
        TIMER_ACT = 8'h00;
        repeat (5) @(posedge CLK_SYS);
        SYS_RST <= 1'b0;
        t_reset_vals();
        t_pause_resume();
        t_stop_reset();
        t_din();
        t_permit();
        end_of_test();
    end
endmodule
